// ### rtl/arp_defines.vh
// Purpose: Named constants for the converter result output port.
// Assumes: Included by the port module only, by bare name.
// Notes:   Offsets are byte addresses on a 32-bit AHB-Lite bus.
`ifndef ARP_DEFINES_VH
`define ARP_DEFINES_VH

// Register byte offsets (low address byte)
`define ARP_OFS_CTRL      8'h00
`define ARP_OFS_RESULT    8'h04
`define ARP_OFS_STATUS    8'h08

// Control register layout and reset value
`define ARP_CTRL_FMT_LO   0
`define ARP_CTRL_FMT_HI   1
`define ARP_CTRL_INTCLK   2
`define ARP_CTRL_W        3
`define ARP_CTRL_RST      3'h4

// Output format codes
`define ARP_FMT_PAR       2'h0
`define ARP_FMT_GATED     2'h1
`define ARP_FMT_CONT      2'h2

// Status register layout
`define ARP_ST_BUSY       0
`define ARP_ST_XFER       1
`define ARP_ST_UBS        2
`define ARP_ST_SEL        3
`define ARP_ST_SCLK       4

// Result layout
`define ARP_RES_W         12
`define ARP_RES_MSB       11
`define ARP_RES_RST       12'h000
`define ARP_BITS_PER_XFER 4'hc
`define ARP_BCNT_W        4
`define ARP_BCNT_RST      4'h0

// Timing counts in converter clock ticks and in hclk cycles
`define ARP_CONV_TICKS    20
`define ARP_INT_DIV       4
`define ARP_CNT_W         16
`define ARP_CNT_RST       16'h0000

// Bus constants
`define ARP_HTRANS_NSEQ   1
`define ARP_HRESP_OKAY    1'h0
`define ARP_WORD_RST      32'h0000_0000

`endif

// ### rtl/arp_port.v
// Purpose: Result output port of a sampling 12-bit converter: parallel,
//          byte and serial delivery to a host, plus AHB-Lite registers.
// Assumes: Software stands in for the conversion engine by writing the
//          result register; host strobes and the clock pin are async.
// Notes:   Pin enables are active low; open-drain pins drive out low only.
`timescale 1ns/1ns
`include "arp_defines.vh"

// Operation
// R1 - Data pins driven only while host holds read strobe and chip select low.
// R2 - Active-low status output shows busy converter, used as interrupt.
// R3 - Converter ticks from external clock pin or internal divider oscillator.
// R4 - Shared MSB pin outputs bit 11 in parallel, byte-select input in byte.
// R5 - Byte mode: low byte when byte select low, upper byte when high.
// R6 - Parallel mode: three serial pins carry result bits 10, 9 and 8.
// R7 - Serial mode: open-drain active-low frame strobe spans each transfer.
// R8 - Open-drain serial clock derived from the converter clock in use.
// R9 - Continuous format keeps the serial clock running between transfers.
// R10 - Gated format stops the serial clock once a transfer has finished.
// R11 - Serial data valid at serial clock falling edges while frame low.
// R12 - Format select chooses parallel, gated serial or continuous serial.
// R13 - Upper byte: four high lanes low, low lanes bits 11 to 8.
module arp_port #(
   parameter CONV_TICKS = `ARP_CONV_TICKS,
   parameter INT_DIV    = `ARP_INT_DIV
) (
   // Clock, reset and enable
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        ce,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output wire [31:0] hrdata,
   // Host strobes, asynchronous pins
   input  wire        chip_select_n,
   input  wire        output_read_n,
   // External converter clock pin
   input  wire        ext_clk,
   // Converter status
   output wire        conversion_status_n,
   // Shared bit 11 / byte select pin
   input  wire        msb_or_byte_select_pin_in,
   output wire        msb_or_byte_select_pin_out,
   output wire        msb_or_byte_select_pin_oe_n,
   // Byte lanes, three-state
   output wire [7:0]  lane_out,
   output wire        lane_oe_n,
   // Shared bit 10 / frame strobe pin
   output wire        bit10_or_frame_pin_out,
   output wire        bit10_or_frame_pin_oe_n,
   // Shared bit 9 / serial clock pin
   output wire        bit9_or_serial_clock_pin_out,
   output wire        bit9_or_serial_clock_pin_oe_n,
   // Shared bit 8 / serial data pin
   output wire        bit8_or_serial_out_pin_out,
   output wire        bit8_or_serial_out_pin_oe_n
);

   // Counter end points, cut to the counter width on purpose
   localparam integer          CONV_LAST_I = CONV_TICKS - 1;
   localparam integer          DIV_LAST_I  = INT_DIV - 1;
   localparam [`ARP_CNT_W-1:0] CONV_LAST = CONV_LAST_I[`ARP_CNT_W-1:0];
   localparam [`ARP_CNT_W-1:0] DIV_LAST  = DIV_LAST_I[`ARP_CNT_W-1:0];

   // Bus side state
   reg                   wr_pend_reg;
   reg  [7:0]            wr_addr_reg;
   reg  [31:0]           hrdata_reg;
   reg  [`ARP_CTRL_W-1:0] ctrl_reg;
   // Pin synchronisers: first stage feeds only the second
   reg  [3:0]            sync1_reg;
   reg  [3:0]            sync2_reg;
   reg                   ext_clk_d_reg;
   // Converter timing
   reg  [`ARP_CNT_W-1:0] div_reg;
   reg                   tick_reg;
   reg  [`ARP_CNT_W-1:0] conv_cnt_reg;
   reg                   busy_reg;
   reg  [`ARP_RES_W-1:0] pend_res_reg;
   reg  [`ARP_RES_W-1:0] result_reg;
   // Serial engine
   reg                   start_reg;
   reg                   xfer_reg;
   reg                   sclk_reg;
   reg                   frame_n_reg;
   reg                   txbit_reg;
   reg  [`ARP_BCNT_W-1:0] bcnt_reg;
   reg  [`ARP_RES_W-1:0] shift_reg;
   // Pin output registers
   reg  [7:0]            lane_reg;
   reg                   lane_oe_n_reg;
   reg  [3:0]            pin_out_reg;
   reg  [3:0]            pin_oe_n_reg;
   reg  [7:0]            lane_next;
   reg  [3:0]            pin_out_next;
   reg  [3:0]            pin_oe_n_next;
   reg  [31:0]           rd_next;

   wire                  accept;
   wire [1:0]            fmt;
   wire                  int_clk;
   wire                  cs_n_s;
   wire                  rd_n_s;
   wire                  ubs_s;
   wire                  ext_clk_s;
   wire                  selected;
   wire                  serial_mode;
   wire                  run_sclk;
   wire                  res_write;

   assign fmt         = ctrl_reg[`ARP_CTRL_FMT_HI:`ARP_CTRL_FMT_LO];
   assign int_clk     = ctrl_reg[`ARP_CTRL_INTCLK];
   assign cs_n_s      = sync2_reg[0];
   assign rd_n_s      = sync2_reg[1];
   assign ubs_s       = sync2_reg[2];
   assign ext_clk_s   = sync2_reg[3];
   // R12 format decode
   assign serial_mode = (fmt != `ARP_FMT_PAR);
   // R1 read window
   assign selected    = ~cs_n_s & ~rd_n_s;

   // Zero wait states; a low enable stalls the bus instead of losing beats
   assign hreadyout = ce;
   assign hresp     = `ARP_HRESP_OKAY;
   assign hrdata    = hrdata_reg;
   assign accept    = hsel & hready & htrans[`ARP_HTRANS_NSEQ];
   assign res_write = wr_pend_reg & (wr_addr_reg == `ARP_OFS_RESULT);

   // Read mux, evaluated in the address phase
   always @* begin
      rd_next = `ARP_WORD_RST;
      case (haddr[7:0])
         `ARP_OFS_CTRL: begin
            rd_next[`ARP_CTRL_W-1:0] = ctrl_reg;
         end
         `ARP_OFS_RESULT: begin
            rd_next[`ARP_RES_W-1:0] = result_reg;
         end
         `ARP_OFS_STATUS: begin
            rd_next[`ARP_ST_BUSY] = busy_reg;
            rd_next[`ARP_ST_XFER] = xfer_reg;
            rd_next[`ARP_ST_UBS]  = ubs_s;
            rd_next[`ARP_ST_SEL]  = selected;
            rd_next[`ARP_ST_SCLK] = sclk_reg;
         end
         default: begin
            rd_next = `ARP_WORD_RST;
         end
      endcase
   end

   // AHB-Lite address and data phases
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= `ARP_OFS_CTRL;
         hrdata_reg  <= `ARP_WORD_RST;
         ctrl_reg    <= `ARP_CTRL_RST;
      end else if (ce) begin
         wr_pend_reg <= accept & hwrite;
         if (accept) begin
            wr_addr_reg <= haddr[7:0];
         end
         if (accept & ~hwrite) begin
            hrdata_reg <= rd_next;
         end
         // Format and clock source steer the whole port
         if (wr_pend_reg && wr_addr_reg == `ARP_OFS_CTRL) begin
            ctrl_reg <= hwdata[`ARP_CTRL_W-1:0];
         end
      end
   end

   // Two-flop synchronisers for host strobes, byte select and clock pin
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg     <= 4'h3;
         sync2_reg     <= 4'h3;
         ext_clk_d_reg <= 1'b0;
      end else if (ce) begin
         sync1_reg     <= {ext_clk, msb_or_byte_select_pin_in,
                           output_read_n, chip_select_n};
         sync2_reg     <= sync1_reg;
         ext_clk_d_reg <= ext_clk_s;
      end
   end

   // R3 converter tick source
   // External edges are seen only after the synchroniser, so the pin
   // clock must stay well below half of hclk.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_reg  <= `ARP_CNT_RST;
         tick_reg <= 1'b0;
      end else if (ce) begin
         if (div_reg == DIV_LAST) begin
            div_reg <= `ARP_CNT_RST;
         end else begin
            div_reg <= div_reg + 1'b1;
         end
         if (int_clk) begin
            tick_reg <= (div_reg == DIV_LAST);
         end else begin
            tick_reg <= ext_clk_s & ~ext_clk_d_reg;
         end
      end
   end

   // R2 conversion timing; writes during busy are ignored
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_reg     <= 1'b0;
         conv_cnt_reg <= `ARP_CNT_RST;
         pend_res_reg <= `ARP_RES_RST;
         result_reg   <= `ARP_RES_RST;
         start_reg    <= 1'b0;
      end else if (ce) begin
         if (res_write && !busy_reg) begin
            busy_reg     <= 1'b1;
            conv_cnt_reg <= `ARP_CNT_RST;
            pend_res_reg <= hwdata[`ARP_RES_W-1:0];
         end else if (busy_reg && tick_reg) begin
            if (conv_cnt_reg == CONV_LAST) begin
               busy_reg   <= 1'b0;
               result_reg <= pend_res_reg;
            end else begin
               conv_cnt_reg <= conv_cnt_reg + 1'b1;
            end
         end
         // Serial request wins over its own clear when both coincide
         if (busy_reg && tick_reg && conv_cnt_reg == CONV_LAST &&
             serial_mode) begin
            start_reg <= 1'b1;
         end else if (tick_reg && !sclk_reg && !xfer_reg) begin
            start_reg <= 1'b0;
         end
      end
   end

   // R9 R10 clock runs always when continuous, else only around a transfer
   assign run_sclk = (fmt == `ARP_FMT_CONT) | xfer_reg | start_reg;

   // R11 serial engine: shift on rising, host samples on falling
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xfer_reg    <= 1'b0;
         sclk_reg    <= 1'b1;
         frame_n_reg <= 1'b1;
         txbit_reg   <= 1'b1;
         bcnt_reg    <= `ARP_BCNT_RST;
         shift_reg   <= `ARP_RES_RST;
      end else if (ce && tick_reg) begin
         if (sclk_reg) begin
            // Falling step: one more bit has been presented
            if (run_sclk) begin
               sclk_reg <= 1'b0;
            end
            if (xfer_reg) begin
               bcnt_reg <= bcnt_reg + 1'b1;
            end
         end else begin
            sclk_reg <= 1'b1;
            if (xfer_reg) begin
               // R7 frame ends after the last falling edge
               if (bcnt_reg == `ARP_BITS_PER_XFER) begin
                  xfer_reg    <= 1'b0;
                  frame_n_reg <= 1'b1;
                  txbit_reg   <= 1'b1;
               end else begin
                  txbit_reg <= shift_reg[`ARP_RES_MSB-1];
                  shift_reg <= {shift_reg[`ARP_RES_MSB-1:0], 1'b0};
               end
            end else if (start_reg) begin
               // R7 frame opens with the MSB on the line
               xfer_reg    <= 1'b1;
               frame_n_reg <= 1'b0;
               bcnt_reg    <= `ARP_BCNT_RST;
               txbit_reg   <= result_reg[`ARP_RES_MSB];
               shift_reg   <= result_reg;
            end
         end
         // Leaving serial format mid-frame abandons the frame
         if (!serial_mode) begin
            xfer_reg    <= 1'b0;
            frame_n_reg <= 1'b1;
         end
      end
   end

   // Pin values; index 3 is the MSB pin, 2..0 the bit10..bit8 pins
   always @* begin
      lane_next     = result_reg[7:0];
      pin_out_next  = 4'h0;
      pin_oe_n_next = 4'hf;
      if (!serial_mode) begin
         // R4 R6 parallel: all twelve bits together, three-state
         pin_out_next  = result_reg[`ARP_RES_MSB:8];
         pin_oe_n_next = {4{~selected}};
      end else begin
         // R5 R13 byte lanes steered by the byte select input
         if (ubs_s) begin
            lane_next = {4'h0, result_reg[`ARP_RES_MSB:8]};
         end
         // R7 R8 R11 open drain: enable low only to pull the line low
         pin_oe_n_next[2] = frame_n_reg;
         pin_oe_n_next[1] = sclk_reg;
         pin_oe_n_next[0] = txbit_reg | frame_n_reg;
      end
   end

   // R1 registered pin drivers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lane_reg      <= 8'h00;
         lane_oe_n_reg <= 1'b1;
         pin_out_reg   <= 4'h0;
         pin_oe_n_reg  <= 4'hf;
      end else if (ce) begin
         lane_reg      <= lane_next;
         lane_oe_n_reg <= ~selected;
         pin_out_reg   <= pin_out_next;
         pin_oe_n_reg  <= pin_oe_n_next;
      end
   end

   // R2 active-low busy indication
   assign conversion_status_n = ~busy_reg;

   assign lane_out                      = lane_reg;
   assign lane_oe_n                     = lane_oe_n_reg;
   // R4 shared pin released in byte formats so the host can drive it
   assign msb_or_byte_select_pin_out    = pin_out_reg[3];
   assign msb_or_byte_select_pin_oe_n   = pin_oe_n_reg[3];
   assign bit10_or_frame_pin_out        = pin_out_reg[2];
   assign bit10_or_frame_pin_oe_n       = pin_oe_n_reg[2];
   assign bit9_or_serial_clock_pin_out  = pin_out_reg[1];
   assign bit9_or_serial_clock_pin_oe_n = pin_oe_n_reg[1];
   assign bit8_or_serial_out_pin_out    = pin_out_reg[0];
   assign bit8_or_serial_out_pin_oe_n   = pin_oe_n_reg[0];

endmodule

// ### tb/arp_host_model.sv
// Purpose: Host side of the result port: strobes, byte select, serial rx.
// Assumes: Pull-ups on the open-drain serial lines.
// Notes:   Released lanes show the inverse of their last driven value.
`timescale 1ns/1ns
module arp_host_model (
   // Clock
   input  logic        hclk,
   // Device pins
   input  logic        msb_or_byte_select_pin_out,
   input  logic        msb_or_byte_select_pin_oe_n,
   input  logic [7:0]  lane_out,
   input  logic        lane_oe_n,
   input  logic        bit10_or_frame_pin_out,
   input  logic        bit10_or_frame_pin_oe_n,
   input  logic        bit9_or_serial_clock_pin_out,
   input  logic        bit9_or_serial_clock_pin_oe_n,
   input  logic        bit8_or_serial_out_pin_out,
   input  logic        bit8_or_serial_out_pin_oe_n,
   // Host drive and received results
   output logic        chip_select_n,
   output logic        output_read_n,
   output logic        msb_or_byte_select_pin_in,
   output logic [11:0] rx_word,
   output int          rx_count,
   output int          sclk_edges
);
   logic       ubs = 1'b0;
   logic [7:0] lane_last = 8'h00;
   logic [11:0] shift = 12'h000;
   logic       frame_q = 1'b1;
   logic       clk_q = 1'b1;
   // Open-drain lines pulled high when released
   wire        frame_lvl = bit10_or_frame_pin_oe_n | bit10_or_frame_pin_out;
   wire        sclk_lvl = bit9_or_serial_clock_pin_oe_n
                          | bit9_or_serial_clock_pin_out;
   wire        data_lvl = bit8_or_serial_out_pin_oe_n
                          | bit8_or_serial_out_pin_out;
   wire [7:0]  lane_lvl = lane_oe_n ? ~lane_last : lane_out;
   // host drives byte select while pin is released
   assign msb_or_byte_select_pin_in = msb_or_byte_select_pin_oe_n ?
                                      ubs : msb_or_byte_select_pin_out;
   initial begin
      chip_select_n = 1'b1;
      output_read_n = 1'b1;
      rx_word = 12'h000;
      rx_count = 0;
      sclk_edges = 0;
   end
   // both strobes held low for the whole read
   task automatic par_read(input logic sel, output logic [11:0] w);
      @(posedge hclk);
      ubs <= sel;
      chip_select_n <= 1'b0;
      output_read_n <= 1'b0;
      repeat (5) @(posedge hclk);
      w = {msb_or_byte_select_pin_in, frame_lvl, sclk_lvl, data_lvl, lane_lvl};
      chip_select_n <= 1'b1;
      output_read_n <= 1'b1;
   endtask
   // sample only at falling clock inside a frame
   always @(posedge hclk) begin
      frame_q <= frame_lvl;
      clk_q <= sclk_lvl;
      if (!lane_oe_n)
         lane_last <= lane_out;
      if (clk_q && !sclk_lvl && !frame_lvl)
         shift <= {shift[10:0], data_lvl};
      if (!frame_q && frame_lvl) begin
         rx_word <= shift;
         rx_count <= rx_count + 1;
      end
      if (clk_q != sclk_lvl)
         sclk_edges <= sclk_edges + 1;
   end
endmodule

// ### tb/arp_port_sva.sv
// Purpose: Port-level assertions for the converter result port.
// Assumes: Bound to arp_port; host strobes reach the pins in 3 edges.
// Notes:   Busy bound allows an external tick every 6 to 8 cycles.
`timescale 1ns/1ns
module arp_port_sva #(
   parameter CONV_TICKS = 20,
   parameter INT_DIV    = 4
) (
   // Clock, reset and bus request
   input logic        hclk,
   input logic        hresetn,
   input logic        hsel,
   input logic        hready,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic [31:0] haddr,
   // Host strobes and pins
   input logic        chip_select_n,
   input logic        output_read_n,
   input logic        conversion_status_n,
   input logic        msb_or_byte_select_pin_in,
   input logic        msb_or_byte_select_pin_oe_n,
   input logic [7:0]  lane_out,
   input logic        lane_oe_n,
   input logic        bit10_or_frame_pin_oe_n,
   input logic        bit9_or_serial_clock_pin_oe_n,
   input logic        bit8_or_serial_out_pin_oe_n
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   int busy_cnt;
   int fall_cnt;
   logic sclk_q;
   logic frame_q;
   // Busy length and clock falls inside a frame; explicit history
   // registers keep the clock of each edge test unambiguous
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_cnt <= 0;
         fall_cnt <= 0;
         sclk_q   <= 1'b1;
         frame_q  <= 1'b1;
      end else begin
         sclk_q   <= bit9_or_serial_clock_pin_oe_n;
         frame_q  <= bit10_or_frame_pin_oe_n;
         busy_cnt <= conversion_status_n ? 0 : busy_cnt + 1;
         if (bit10_or_frame_pin_oe_n)
            fall_cnt <= 0;
         else if (sclk_q && !bit9_or_serial_clock_pin_oe_n && !frame_q)
            fall_cnt <= fall_cnt + 1;
      end
   end
   // Result write accepted while idle
   sequence s_res_wr;
      hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h04
         && conversion_status_n ##1 conversion_status_n;
   endsequence
   // Serial frame closing after shifting
   sequence s_frame_end;
      $rose(bit10_or_frame_pin_oe_n) && fall_cnt != 0;
   endsequence
   property p_lane_cause;
      !lane_oe_n |-> $past(chip_select_n, 3) == 1'b0
         && $past(output_read_n, 3) == 1'b0;
   endproperty
   property p_msb_lane;
      !msb_or_byte_select_pin_oe_n |-> !lane_oe_n;
   endproperty
   property p_par_pins;
      !msb_or_byte_select_pin_oe_n |-> !bit10_or_frame_pin_oe_n
         && !bit9_or_serial_clock_pin_oe_n && !bit8_or_serial_out_pin_oe_n;
   endproperty
   property p_upper_zero;
      !lane_oe_n && msb_or_byte_select_pin_oe_n
         && $past(msb_or_byte_select_pin_in, 3) |-> lane_out[7:4] == 4'h0;
   endproperty
   property p_busy_start;
      s_res_wr |-> ##[1:2] !conversion_status_n;
   endproperty
   property p_busy_len;
      $rose(conversion_status_n) |-> busy_cnt >= (CONV_TICKS - 1) * INT_DIV
         && busy_cnt <= CONV_TICKS * 8 + 8;
   endproperty
   property p_data_on_rise;
      !bit10_or_frame_pin_oe_n && $past(bit10_or_frame_pin_oe_n) == 1'b0
         && $changed(bit8_or_serial_out_pin_oe_n)
         |-> $rose(bit9_or_serial_clock_pin_oe_n);
   endproperty
   property p_frame_bits;
      s_frame_end |-> fall_cnt == 12;
   endproperty
   a_lane_cause: assert property (p_lane_cause)
      else $error("lanes driven without host strobes");
   a_msb_lane: assert property (p_msb_lane)
      else $error("top bit pin driven without lanes");
   a_par_pins: assert property (p_par_pins)
      else $error("parallel pins not driven together");
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper byte high lanes not low");
   a_busy_start: assert property (p_busy_start)
      else $error("status did not go busy after result write");
   a_busy_len: assert property (p_busy_len)
      else $error("busy length out of range");
   a_data_on_rise: assert property (p_data_on_rise)
      else $error("serial data moved off a rising clock");
   a_frame_bits: assert property (p_frame_bits)
      else $error("frame did not carry twelve clock falls");
endmodule

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the converter result port.
// Assumes: Short conversion counts; host model on the pin side.
// Notes:   External clock made from hclk, one rise per 6 cycles.
`timescale 1ns/1ns
module tb_top;
   localparam CONV_TICKS = 4;
   localparam INT_DIV    = 2;
   // Bus side
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        ce = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        ext_clk = 1'b0;
   logic        hready, hreadyout, hresp;
   logic [31:0] hrdata;
   // Pin side
   logic        chip_select_n, output_read_n, conversion_status_n;
   logic        msb_or_byte_select_pin_in, msb_or_byte_select_pin_out;
   logic        msb_or_byte_select_pin_oe_n, lane_oe_n;
   logic [7:0]  lane_out;
   logic        bit10_or_frame_pin_out, bit10_or_frame_pin_oe_n;
   logic        bit9_or_serial_clock_pin_out, bit9_or_serial_clock_pin_oe_n;
   logic        bit8_or_serial_out_pin_out, bit8_or_serial_out_pin_oe_n;
   logic [11:0] rx_word, w;
   logic [31:0] d;
   int          rx_count, sclk_edges, n, e;
   int          failures = 0;
   int          checks_done = 0;
   int          cycles = 0;
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   arp_port #(.CONV_TICKS(CONV_TICKS), .INT_DIV(INT_DIV)) DUT (.*);
   arp_host_model HOST (.*);
   task automatic results;
      if (failures == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // External clock and hang guard
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles % 3 == 0)
         ext_clk <= ~ext_clk;
      if (cycles == 20000) begin
         failures++;
         results;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One single AHB-Lite word transfer
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(d, exp);
   endtask
   // Wait for busy to start, then to end
   task automatic wait_conv;
      int i;
      for (i = 0; i < 4 && conversion_status_n !== 1'b0; i++)
         @(posedge hclk);
      chk(conversion_status_n, 1'b0);
      for (i = 0; i < 2000 && conversion_status_n !== 1'b1; i++)
         @(posedge hclk);
      chk(conversion_status_n, 1'b1);
   endtask
   task automatic wait_frame;
      int i;
      for (i = 0; i < 3000 && rx_count == n; i++)
         @(posedge hclk);
      chk(rx_count, n + 1);
   endtask
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(8'h00, 32'h0000_0004);
      rd_chk(8'h0c, 32'h0000_0000);
      rd_chk(8'h08, 32'h0000_0010);
      // Parallel word; second write lands while busy
      bus(1'b1, 8'h04, 32'h0000_0a5c);
      bus(1'b1, 8'h04, 32'h0000_0123);
      wait_conv();
      rd_chk(8'h04, 32'h0000_0a5c);
      HOST.par_read(1'b0, w);
      chk(w, 12'ha5c);
      repeat (4) @(posedge hclk);
      chk(lane_oe_n, 1'b1);
      // Gated serial then byte reads
      bus(1'b1, 8'h00, 32'h0000_0005);
      rd_chk(8'h00, 32'h0000_0005);
      n = rx_count;
      bus(1'b1, 8'h04, 32'h0000_09e7);
      wait_conv();
      wait_frame();
      chk(rx_word, 12'h9e7);
      repeat (4) @(posedge hclk);
      e = sclk_edges;
      repeat (40) @(posedge hclk);
      chk(sclk_edges, e);
      HOST.par_read(1'b1, w);
      chk(w[7:0], 8'h09);
      HOST.par_read(1'b0, w);
      chk(w[7:0], 8'he7);
      // Continuous serial on the external clock
      bus(1'b1, 8'h00, 32'h0000_0002);
      n = rx_count;
      bus(1'b1, 8'h04, 32'h0000_036b);
      wait_conv();
      wait_frame();
      chk(rx_word, 12'h36b);
      e = sclk_edges;
      repeat (40) @(posedge hclk);
      chk(sclk_edges != e, 1'b1);
      results;
   end
endmodule
bind arp_port arp_port_sva #(.CONV_TICKS(CONV_TICKS), .INT_DIV(INT_DIV))
   u_sva (.*);
